//--- core/adcss_pkg.sv
// Purpose: Shared constants and types for the converter sweep sequencer
// Assumes: APB slave with 32-bit data, byte addresses on an 8-bit bus
// Notes:   Group codes and field positions are shared with the bench
package adcss_pkg;

  // Register byte addresses
  localparam logic [7:0] ADCSS_OFF_CTRL0     = 8'h00;
  localparam logic [7:0] ADCSS_OFF_CTRL1     = 8'h04;
  localparam logic [7:0] ADCSS_OFF_CTRL2     = 8'h08;
  localparam logic [7:0] ADCSS_OFF_TRGCON    = 8'h0c;
  localparam logic [7:0] ADCSS_OFF_INT_STAT  = 8'h10;
  localparam logic [7:0] ADCSS_OFF_INT_CLR   = 8'h14;
  localparam logic [7:0] ADCSS_OFF_INT_EN    = 8'h18;
  localparam logic [7:0] ADCSS_OFF_RESULT    = 8'h20;
  localparam logic [7:0] ADCSS_OFF_RESULT_HI = 8'h3c;

  // converter_control_0 fields
  localparam int ADCSS_C0_MODE  = 0;
  localparam int ADCSS_C0_TRG   = 1;
  localparam int ADCSS_C0_START = 2;
  // converter_control_1 fields (scan_width_lo/hi)
  localparam int ADCSS_C1_SCAN  = 0;
  // converter_control_2 fields
  localparam int ADCSS_C2_SMP   = 0;
  localparam int ADCSS_C2_GROUP = 1;
  // Trigger control fields
  localparam int ADCSS_TC_SRC   = 0;
  localparam int ADCSS_TC_TMR   = 1;

  // Mode bit values
  localparam logic ADCSS_MODE_REPEAT1 = 1'b0;
  localparam logic ADCSS_MODE_SIMUL   = 1'b1;

  // Input group codes; 2'b01 must not be programmed
  localparam logic [1:0] ADCSS_GRP_FIRST  = 2'h0;
  localparam logic [1:0] ADCSS_GRP_ILLEGAL = 2'h1;
  localparam logic [1:0] ADCSS_GRP_SECOND = 2'h2;
  localparam logic [1:0] ADCSS_GRP_THIRD  = 2'h3;

  // Reset values and highest channel number
  localparam logic [1:0] ADCSS_RST_GROUP = 2'h0;
  localparam logic [2:0] ADCSS_RST_SYNC  = 3'h7;
  localparam logic [2:0] ADCSS_NUM_CHAN  = 3'h7;

  typedef enum logic [1:0] {
    ADCSS_IDLE,
    ADCSS_ARMED,
    ADCSS_ISSUE,
    ADCSS_WAIT
  } adcss_seq_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } adcss_apb_s;

  typedef struct packed {
    logic       start;
    logic [2:0] channel;
    logic [1:0] group;
    logic       sample_hold;
    logic       simul;
  } adcss_conv_s;

endpackage

//--- core/adcss_top.sv
// Purpose: Sequencer for repeat sweep mode 1 and simultaneous sample sweep
// Assumes: Conversion core answers each start with one conv_done pulse
// Notes:   All APB answers take no wait state; results are 10 bits
`timescale 1ns/1ns
`default_nettype none

// How it works
// - sample_hold_select picks conversion method
// - Input group field selects port group
// - Repeat mode 1 converts until stopped
// - Repeat mode 1 interleaves input 0
// - Software trigger starts on flag write
// - External falling edge starts after flag set
// - Writing flag 0 halts conversion
// - Repeat mode 1 never interrupts
// - Repeat mode 1 sweeps one to four inputs
// - Result stored per converted input
// - Simultaneous mode samples inputs 0,1 together
// - Further bits choose hardware source
// - Timer underflows start after flag set
// - Simultaneous sweep ends, interrupts; software trigger clears flag, hardware trigger rearms
// - Simultaneous mode sweeps 2 to 8
// - Timer B0 underflow usable as trigger
// - Trigger decode table for simultaneous mode
module adcss_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire adcss_pkg::adcss_apb_s apb,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                ext_trigger_pin_n,
  input  wire logic                tb0_underflow,
  input  wire logic                tb2_underflow,
  input  wire logic                conv_done,
  input  wire logic [9:0]          conv_result,
  output adcss_pkg::adcss_conv_s   conv,
  output logic                     irq
);
  import adcss_pkg::*;

  typedef struct packed {
    logic             mode;
    logic             trig_sel;
    logic             start_flag;
    logic [1:0]       scan;
    logic             sample_hold_select;
    logic [1:0]       group;
    logic             trg_src;
    logic             tmr_trg;
    logic             int_status;
    logic             int_enable;
    logic [7:0][9:0]  result;
    adcss_seq_e       seq;
    logic [2:0]       chan;
    logic [2:0]       other;
    logic             odd;
    logic [2:0]       ext_sync;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             conv_start;
    logic             conv_simul;
    logic             irq;
  } adcss_state_s;

  adcss_state_s st;
  adcss_state_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'h0) &&
                  ((a <= ADCSS_OFF_INT_EN) ||
                   (a >= ADCSS_OFF_RESULT && a <= ADCSS_OFF_RESULT_HI));
  endfunction

  // Last channel of a sweep: repeat mode 1 uses 0..scan, simultaneous 0..2scan+1
  function automatic logic [2:0] last_chan(input logic mode, input logic [1:0] scan);
    if (mode == ADCSS_MODE_SIMUL) begin
      last_chan = {scan, 1'b1};
    end else begin
      last_chan = {1'b0, scan};
    end
  endfunction

  function automatic logic [31:0] reg_read(input adcss_state_s s, input logic [7:0] a);
    reg_read = 32'h0;
    // Unmapped or misaligned words read zero, even inside the result window
    if (!addr_mapped(a)) begin
      reg_read = 32'h0;
    end else if (a >= ADCSS_OFF_RESULT) begin
      reg_read = {22'h0, s.result[a[4:2]]};
    end else begin
      unique case (a)
        ADCSS_OFF_CTRL0: begin
          reg_read[ADCSS_C0_MODE]  = s.mode;
          reg_read[ADCSS_C0_TRG]   = s.trig_sel;
          reg_read[ADCSS_C0_START] = s.start_flag;
        end
        ADCSS_OFF_CTRL1:    reg_read[ADCSS_C1_SCAN +: 2] = s.scan;
        ADCSS_OFF_CTRL2: begin
          reg_read[ADCSS_C2_SMP]       = s.sample_hold_select;
          reg_read[ADCSS_C2_GROUP +: 2] = s.group;
        end
        ADCSS_OFF_TRGCON: begin
          reg_read[ADCSS_TC_SRC] = s.trg_src;
          reg_read[ADCSS_TC_TMR] = s.tmr_trg;
        end
        ADCSS_OFF_INT_STAT: reg_read[0] = s.int_status;
        ADCSS_OFF_INT_EN:   reg_read[0] = s.int_enable;
        default:            reg_read = 32'h0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic ext_fall;
  logic hw_hit;
  logic done_evt;
  logic setup;
  logic wr;

  // Stage 0 of ext_sync feeds only stage 1; edge looks at stages 1 and 2
  assign ext_fall = st.ext_sync[2] & ~st.ext_sync[1];
  assign setup    = apb.psel & ~apb.penable;
  assign wr       = apb.psel & apb.penable & st.pready & apb.pwrite & addr_mapped(apb.paddr);

  always_comb begin
    next_st            = st;
    next_st.pready     = 1'b0;
    next_st.pslverr    = 1'b0;
    next_st.conv_start = 1'b0;
    next_st.ext_sync   = {st.ext_sync[1:0], ext_trigger_pin_n};
    done_evt           = 1'b0;

    // Hardware trigger decode
    if (st.mode == ADCSS_MODE_REPEAT1) begin
      hw_hit = ext_fall;
    end else if (st.tmr_trg) begin
      hw_hit = tb0_underflow;
    end else if (st.trg_src) begin
      hw_hit = tb2_underflow;
    end else begin
      hw_hit = ext_fall;
    end

    unique case (st.seq)
      ADCSS_IDLE: begin
      end
      // Only reached with the flag set, so early edges are dropped
      ADCSS_ARMED: begin
        if (hw_hit) begin
          next_st.seq = ADCSS_ISSUE;
        end
      end
      ADCSS_ISSUE: begin
        next_st.conv_start = 1'b1;
        next_st.conv_simul = (st.mode == ADCSS_MODE_SIMUL) && (st.chan == 3'h0);
        next_st.seq        = ADCSS_WAIT;
      end
      ADCSS_WAIT: begin
        if (conv_done) begin
          next_st.result[st.chan] = conv_result;
          if (st.mode == ADCSS_MODE_REPEAT1) begin
            next_st.seq = ADCSS_ISSUE;
            if (st.odd) begin
              next_st.odd  = 1'b0;
              next_st.chan = 3'h0;
              if (st.other >= last_chan(st.mode, st.scan)) begin
                next_st.other = 3'h1;
              end else begin
                next_st.other = st.other + 3'h1;
              end
            end else if (st.scan != 2'h0) begin
              next_st.odd  = 1'b1;
              next_st.chan = st.other;
            end
          end else if (st.chan == last_chan(st.mode, st.scan)) begin
            done_evt     = 1'b1;
            next_st.chan = 3'h0;
            if (st.trig_sel) begin
              next_st.seq = ADCSS_ARMED;
            end else begin
              next_st.seq        = ADCSS_IDLE;
              next_st.start_flag = 1'b0;
            end
          end else begin
            next_st.chan = st.chan + 3'h1;
            next_st.seq  = ADCSS_ISSUE;
          end
        end
      end
    endcase

    // Register bus: no wait state, data latched in setup
    if (setup) begin
      next_st.pready  = 1'b1;
      next_st.prdata  = reg_read(st, apb.paddr);
      next_st.pslverr = ~addr_mapped(apb.paddr);
    end

    // Software writes come after the sequencer so a halt always wins
    if (wr) begin
      unique case (apb.paddr)
        ADCSS_OFF_CTRL0: begin
          next_st.mode       = apb.pwdata[ADCSS_C0_MODE];
          next_st.trig_sel   = apb.pwdata[ADCSS_C0_TRG];
          next_st.start_flag = apb.pwdata[ADCSS_C0_START];
          if (!apb.pwdata[ADCSS_C0_START]) begin
            next_st.seq = ADCSS_IDLE;
          end else if (!st.start_flag) begin
            next_st.chan  = 3'h0;
            next_st.other = 3'h1;
            next_st.odd   = 1'b0;
            if (apb.pwdata[ADCSS_C0_TRG]) begin
              next_st.seq = ADCSS_ARMED;
            end else begin
              next_st.seq = ADCSS_ISSUE;
            end
          end
        end
        ADCSS_OFF_CTRL1:  next_st.scan = apb.pwdata[ADCSS_C1_SCAN +: 2];
        ADCSS_OFF_CTRL2: begin
          next_st.sample_hold_select   = apb.pwdata[ADCSS_C2_SMP];
          next_st.group = apb.pwdata[ADCSS_C2_GROUP +: 2];
        end
        ADCSS_OFF_TRGCON: begin
          next_st.trg_src = apb.pwdata[ADCSS_TC_SRC];
          next_st.tmr_trg = apb.pwdata[ADCSS_TC_TMR];
        end
        ADCSS_OFF_INT_CLR: begin
          if (apb.pwdata[0]) begin
            next_st.int_status = 1'b0;
          end
        end
        ADCSS_OFF_INT_EN: next_st.int_enable = apb.pwdata[0];
        default: begin
        end
      endcase
    end

    // A completion in the clearing cycle still sets the bit
    if (done_evt) begin
      next_st.int_status = 1'b1;
    end
    next_st.irq = next_st.int_status & next_st.int_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.group    <= ADCSS_RST_GROUP;
      st.seq      <= ADCSS_IDLE;
      st.other    <= 3'h1;
      st.ext_sync <= ADCSS_RST_SYNC;
    end else begin
      st <= next_st;
    end
  end

  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign irq              = st.irq;
  assign conv.start       = st.conv_start;
  assign conv.channel     = st.chan;
  assign conv.group       = st.group;
  assign conv.sample_hold = st.sample_hold_select;
  assign conv.simul       = st.conv_simul;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_ctrl0;
  assign wr_ctrl0 = wr && (apb.paddr == ADCSS_OFF_CTRL0);

  sequence s_issue;
    (st.seq == ADCSS_ISSUE) ##1 (st.conv_start && st.seq == ADCSS_WAIT);
  endsequence

  property p_sw_start;
    wr_ctrl0 && apb.pwdata[ADCSS_C0_START] && !apb.pwdata[ADCSS_C0_TRG] && !st.start_flag
      |=> s_issue;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("Software start did not issue");

  property p_halt;
    wr_ctrl0 && !apb.pwdata[ADCSS_C0_START] |=> (st.seq == ADCSS_IDLE) && !st.start_flag;
  endproperty
  a_halt: assert property (p_halt) else $error("Flag clear did not halt");

  property p_no_irq_rep1;
    $rose(st.int_status) |-> $past(st.mode) == ADCSS_MODE_SIMUL;
  endproperty
  a_no_irq_rep1: assert property (p_no_irq_rep1) else $error("Interrupt in repeat mode");

  property p_interleave;
    st.seq == ADCSS_WAIT && conv_done && st.mode == ADCSS_MODE_REPEAT1 && st.odd
      |=> st.chan == 3'h0 ##0 s_issue;
  endproperty
  a_interleave: assert property (p_interleave) else $error("Input 0 not interleaved");

  property p_result;
    st.seq == ADCSS_WAIT && conv_done |=> st.result[$past(st.chan)] == $past(conv_result);
  endproperty
  a_result: assert property (p_result) else $error("Result not stored");

  property p_sim_end;
    st.seq == ADCSS_WAIT && conv_done && st.mode == ADCSS_MODE_SIMUL && !st.trig_sel &&
      st.chan == last_chan(st.mode, st.scan) && !wr
      |=> !st.start_flag && st.int_status && st.seq == ADCSS_IDLE ##1 st.irq == st.int_enable;
  endproperty
  a_sim_end: assert property (p_sim_end) else $error("Sweep end wrong");

  property p_ext_start;
    st.seq == ADCSS_ARMED && ext_fall && !wr &&
      (st.mode == ADCSS_MODE_REPEAT1 || (!st.tmr_trg && !st.trg_src)) |=> s_issue;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("External edge missed");

  property p_idle_flag;
    !st.start_flag |-> st.seq == ADCSS_IDLE;
  endproperty
  a_idle_flag: assert property (p_idle_flag) else $error("Running with flag clear");

  property p_simul;
    st.conv_start |-> st.conv_simul == (st.mode == ADCSS_MODE_SIMUL && st.chan == 3'h0);
  endproperty
  a_simul: assert property (p_simul) else $error("Simultaneous sample flag wrong");

  property p_tb0;
    st.seq == ADCSS_ARMED && st.mode == ADCSS_MODE_SIMUL && st.tmr_trg && tb0_underflow && !wr
      |=> st.seq == ADCSS_ISSUE;
  endproperty
  a_tb0: assert property (p_tb0) else $error("Timer B0 trigger missed");

  property p_tb2;
    st.seq == ADCSS_ARMED && st.mode == ADCSS_MODE_SIMUL && !st.tmr_trg && st.trg_src &&
      tb2_underflow && !wr |=> st.seq == ADCSS_ISSUE;
  endproperty
  a_tb2: assert property (p_tb2) else $error("Timer B2 trigger missed");

  // Armed state must hold until the chosen source fires
  property p_armed_hold;
    st.seq == ADCSS_ARMED && !hw_hit && !wr |=> st.seq == ADCSS_ARMED;
  endproperty
  a_armed_hold: assert property (p_armed_hold) else $error("Started without trigger");

  property p_rep1_loop;
    st.seq == ADCSS_WAIT && conv_done && st.mode == ADCSS_MODE_REPEAT1 && !wr
      |=> st.seq == ADCSS_ISSUE && st.start_flag;
  endproperty
  a_rep1_loop: assert property (p_rep1_loop) else $error("Repeat sweep stopped itself");

  property p_sim_step;
    st.seq == ADCSS_WAIT && conv_done && st.mode == ADCSS_MODE_SIMUL &&
      st.chan != last_chan(st.mode, st.scan) && !wr
      |=> st.chan == $past(st.chan) + 3'h1 && st.seq == ADCSS_ISSUE;
  endproperty
  a_sim_step: assert property (p_sim_step) else $error("Sweep step wrong");

  property p_cfg;
    wr && apb.paddr == ADCSS_OFF_CTRL2
      |=> conv.sample_hold == $past(apb.pwdata[ADCSS_C2_SMP]) &&
          conv.group == $past(apb.pwdata[ADCSS_C2_GROUP +: 2]);
  endproperty
  a_cfg: assert property (p_cfg) else $error("Method or group not applied");

endmodule
`default_nettype wire

//--- test/adcss_core_model.sv
// Purpose: Behavioural converter core facing the sweep sequencer
// Assumes: One conv_done pulse answers each conv.start
// Notes:   Result encodes hold bit, group and channel for the bench
`timescale 1ns/1ns
`default_nettype none
module adcss_core_model (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire adcss_pkg::adcss_conv_s conv,
  input  wire logic                   slow,
  output logic                        conv_done,
  output logic [9:0]                  conv_result
);
  import adcss_pkg::*;
  int         cnt;
  logic [9:0] res;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      conv_done <= 1'b0;
      conv_result <= 10'h000;
    end else begin
      conv_done <= (cnt == 1);
      // Result only valid with done; garbage otherwise
      conv_result <= (cnt == 1) ? res : ~conv_result;
      if (conv.start) begin
        cnt <= slow ? 9 : 2;
        res <= {conv.sample_hold, conv.group, 4'h0, conv.channel};
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/test_adc_sweep_sequencer.sv
// Purpose: Self-checking bench for the converter sweep sequencer
// Assumes: Zero-wait-state APB slave, core model as converter
// Notes:   Register rows first, then sweeps and trigger sources
`timescale 1ns/1ns
`default_nettype none
module test_adc_sweep_sequencer;
  import adcss_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic        x;
  } adcss_row_s;
  logic        pclk, presetn, pin_n, tb0, tb2, slow, done, irq, pready, pslverr, se;
  logic        seen = 1'b0;
  adcss_apb_s  bus;
  adcss_conv_s conv;
  logic [31:0] prdata, rd;
  logic [9:0]  res;
  logic [2:0]  q_ch[$];
  logic        q_sim[$];
  int          err_total, samples_checked, cyc, s, i;
  logic [1:0]  tc[3] = '{2'h0, 2'h2, 2'h1};
  adcss_row_s  rows[12] = '{
    '{ADCSS_OFF_CTRL1, 32'h3, 32'h3, 1'b0}, '{ADCSS_OFF_CTRL2, 32'h1, 32'h1, 1'b0},
    '{ADCSS_OFF_CTRL2, 32'h6, 32'h6, 1'b0}, '{ADCSS_OFF_CTRL2, 32'h4, 32'h4, 1'b0},
    '{ADCSS_OFF_CTRL2, 32'h0, 32'h0, 1'b0}, '{ADCSS_OFF_TRGCON, 32'h3, 32'h3, 1'b0},
    '{ADCSS_OFF_INT_EN, 32'hffffffff, 32'h1, 1'b0}, '{ADCSS_OFF_INT_EN, 32'h0, 32'h0, 1'b0},
    '{ADCSS_OFF_INT_STAT, 32'h1, 32'h0, 1'b0}, '{ADCSS_OFF_RESULT, 32'h3ff, 32'h0, 1'b0},
    '{8'h40, 32'h1, 32'h0, 1'b1}, '{8'h06, 32'h1, 32'h0, 1'b1}};
  adcss_top u_adcss_top (.pclk(pclk), .presetn(presetn), .apb(bus), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trigger_pin_n(pin_n), .tb0_underflow(tb0),
    .tb2_underflow(tb2), .conv_done(done), .conv_result(res), .conv(conv), .irq(irq));
  adcss_core_model u_adcss_core_model (.pclk(pclk), .presetn(presetn), .conv(conv),
    .slow(slow), .conv_done(done), .conv_result(res));
  ////////////////////////////////////////////////////////////////////////////////
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (conv.start === 1'b1) begin
      q_ch.push_back(conv.channel);
      q_sim.push_back(conv.simul);
    end
    if (irq === 1'b1 && conv.simul === 1'b0 && q_sim.size() > 0 && q_sim[0] === 1'b0) seen = 1;
    if (cyc > 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, v);
    end
  endtask
  // Request held until pready is seen high at a rising edge; hang caught by watchdog
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    bus <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    bus.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    se = pslverr;
    bus.psel <= 1'b0;
    bus.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin @(posedge pclk); n++; end
    chk("irq", 1, irq);
    @(posedge pclk);
  endtask
  task automatic pulse(int k);
    case (k)
      0: begin pin_n <= 1'b0; repeat (6) @(posedge pclk); pin_n <= 1'b1; end
      1: begin tb0 <= 1'b1; @(posedge pclk); tb0 <= 1'b0; end
      default: begin tb2 <= 1'b1; @(posedge pclk); tb2 <= 1'b0; end
    endcase
    repeat (8) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, tb0, tb2, slow} = '0;
    pin_n = 1'b1;
    bus = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("conv idle", 0, conv);
    for (i = 0; i < 7; i++) begin xfer(0, 8'(4 * i), 0); chk("reset", 0, rd); end
    foreach (rows[r]) begin
      xfer(1, rows[r].a, rows[r].d);
      chk("wr err", rows[r].x, se);
      xfer(0, rows[r].a, 0);
      chk("read", rows[r].e, rd);
      chk("rd err", rows[r].x, se);
      if (rows[r].a == ADCSS_OFF_CTRL2) chk("conv cfg", rows[r].d[2:0], {conv.group, conv.sample_hold});
    end
    // Repeat mode 1, slow core, scan over inputs 0 to 2
    xfer(1, ADCSS_OFF_CTRL2, 32'h5);
    xfer(1, ADCSS_OFF_CTRL1, 32'h2);
    // Enabled here so a stray repeat-mode interrupt would show on irq
    xfer(1, ADCSS_OFF_INT_EN, 32'h1);
    slow <= 1'b1;
    xfer(1, ADCSS_OFF_CTRL0, 32'h4);
    for (i = 0; i < 400 && q_ch.size() < 8; i++) @(posedge pclk);
    xfer(1, ADCSS_OFF_CTRL0, 32'h0);
    s = q_ch.size();
    for (i = 0; i < 8; i++) chk("order", (i % 2) ? 3'((i / 2) % 2 + 1) : 3'h0, q_ch[i]);
    repeat (40) @(posedge pclk);
    chk("halted", s, q_ch.size());
    chk("no irq", 0, seen);
    xfer(0, ADCSS_OFF_INT_STAT, 0);
    chk("rep status", 0, rd);
    for (i = 0; i < 3; i++) begin
      xfer(0, ADCSS_OFF_RESULT + 8'(4 * i), 0);
      chk("result", {22'h0, 1'b1, 2'h2, 4'h0, 3'(i)}, rd);
    end
    // Result 0 now holds data, so an unmapped read must still give zero
    xfer(0, 8'h40, 0);
    chk("unmapped rd", 0, rd);
    chk("unmapped err", 1, se);
    // Simultaneous mode, software trigger, eight inputs
    slow <= 1'b0;
    q_ch.delete();
    q_sim.delete();
    xfer(1, ADCSS_OFF_CTRL1, 32'h3);
    xfer(1, ADCSS_OFF_CTRL0, 32'h5);
    wait_irq();
    chk("count", 8, q_ch.size());
    for (i = 0; i < 8; i++) chk("seq", i, q_ch[i]);
    chk("simul", 1, q_sim[0]);
    xfer(0, ADCSS_OFF_CTRL0, 0);
    chk("autoclear", 32'h1, rd);
    xfer(0, ADCSS_OFF_INT_STAT, 0);
    chk("status", 32'h1, rd);
    xfer(1, ADCSS_OFF_INT_CLR, 32'h1);
    xfer(0, ADCSS_OFF_INT_STAT, 0);
    chk("cleared", 32'h0, rd);
    chk("irq low", 0, irq);
    // Hardware sources: early edge and wrong source must not start
    xfer(1, ADCSS_OFF_CTRL1, 32'h0);
    for (s = 0; s < 3; s++) begin
      q_ch.delete();
      xfer(1, ADCSS_OFF_TRGCON, 32'(tc[s]));
      xfer(1, ADCSS_OFF_CTRL0, 32'h3);
      pulse(s);
      xfer(1, ADCSS_OFF_CTRL0, 32'h7);
      pulse((s + 1) % 3);
      chk("no start", 0, q_ch.size());
      pulse(s);
      wait_irq();
      chk("hw sweep", 2, q_ch.size());
      xfer(0, ADCSS_OFF_CTRL0, 0);
      chk("rearmed", 32'h7, rd);
      xfer(1, ADCSS_OFF_INT_CLR, 32'h1);
      xfer(1, ADCSS_OFF_CTRL0, 32'h0);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
